// [stm_params.svh]
`ifndef STM_PARAMS_SVH
`define STM_PARAMS_SVH
// What this block does
// - Compare A match drives pin high, low or toggles; action zero holds.
// - Match requesting the level already on the pin shows no change.
// - Enable bit rising edge returns pin to the initial level.
// - Initial-level bit sets start level, or active level in PWM.
// - Invert bit inverts the pin; no effect in timer/counter mode.
// - Swap bit exchanges period and duty roles of compare A and P.
// - Clear-select picks A match, or P match/overflow, to clear counter.
// - Overflow clear only with P value zero; period is 65536 clocks.
// - Clear-select ignored in PWM, single-pulse and capture modes.
// - Counter reads as low and high read-only bytes, zero at reset.
// - Compare A is two read/write bytes, all 16 bits compared.
// - P value compares counter bits 15..8; period is N times 256.
// - Mode field 00 is compare output; clear by overflow, A or P.
// - Clear-select 0 in compare mode sets both A and P flags.
// - Clear-select 1 in compare mode sets only the A flag.
// - In compare mode only A matches move the pin; P matches leave it alone.
// - Mode 00 compare, 01 capture, 10 PWM/pulse, 11 timer/counter.
// - Enable rise zeroes the counter; enable fall freezes it.

// ==========================================
// Register offsets (byte addresses)
`define OFS_CTRL0   8'h00
`define OFS_CTRL1   8'h04
`define OFS_CNT_LO  8'h08
`define OFS_CNT_HI  8'h0C
`define OFS_CMPA_LO 8'h10
`define OFS_CMPA_HI 8'h14
`define OFS_CMPP    8'h18
`define OFS_FLAGS   8'h1C

// ==========================================
// Field positions
`define C0_PAUSE 7
`define C0_EN    3
`define C1_INIT  3
`define C1_INV   2
`define C1_DPX   1
`define C1_CCLR  0
`define FL_A     0
`define FL_P     1

// ==========================================
// Reset values
`define RST_BYTE 8'h00
`define RST_WORD 16'h0000
`endif

// [stm_pkg.sv]
package stm_pkg;
   // Operating mode, in field order
   typedef enum logic [1:0] {
      MODE_COMPARE,
      MODE_CAPTURE,
      MODE_PWM,
      MODE_COUNT
   } mode_t;
   // Output action field, compare mode meaning
   typedef enum logic [1:0] {
      ACT_HOLD,
      ACT_LOW,
      ACT_HIGH,
      ACT_TOGGLE
   } action_t;
   typedef logic [7:0] addr_t;
   typedef logic [7:0] byte_t;
endpackage

// [standard_timer.sv]
`include "stm_params.svh"
module standard_timer #(
   parameter int SUB_DIV = 640  // Slow clock divider
) (
   input  wire logic          clock,     // 20 MHz clock
   input  wire logic          rst,       // Async reset
   input  wire logic          psel,      // APB select
   input  wire logic          penable,   // APB enable
   input  wire logic          pwrite,    // APB direction
   input  wire stm_pkg::addr_t paddr,    // APB address
   input  wire logic [31:0]   pwdata,    // APB write data
   output logic [31:0]        prdata,    // APB read data
   output logic               pready,    // APB ready
   output logic               pslverr,   // APB error
   input  wire logic          ext_clk,   // External count pin
   input  wire logic          cap_in,    // Capture input pin
   output logic               timer_output_pin // Timer output
);
   import stm_pkg::*;

   // ==========================================
   // Elaboration check
   generate
      if (SUB_DIV < 2 || SUB_DIV > 65536) begin : g_bad
         $error("SUB_DIV must lie between 2 and 65536");
      end
   endgenerate

   // ==========================================
   // Declarations
   byte_t       ctrl0_ff;
   byte_t       timer_control_one;
   logic [15:0] cnt_ff;
   logic [15:0] cmp_a_ff;
   byte_t       compare_p_reg;
   logic        flag_a_ff;
   logic        flag_p_ff;
   logic        en_prev_ff;
   logic        pin_lvl_ff;
   logic [5:0]  pre_ff;
   logic [15:0] sub_ff;
   logic [2:0]  ext_sync_ff;
   logic [2:0]  cap_sync_ff;
   logic [31:0] prdata_ff;
   logic        pready_ff;
   logic        pslverr_ff;
   logic        out_pin_ff;

   mode_t       mode;
   action_t     act;
   logic        counter_enable_bit;
   logic        initial_level_ctrl;
   logic        output_invert;
   logic        duty_period_swap;
   logic        clear_select;
   logic        src_tick;
   logic        tick;
   logic        en_rise;
   logic [15:0] cnt_inc;
   logic        a_hit;
   logic        p_hit;
   logic        cnt_clr;
   logic        single;
   logic        pwm_on;
   logic [16:0] duty;
   logic        cap_evt;
   logic        set_a;
   logic        set_p;
   logic        nxt_pin;
   logic        wr_go;
   logic        rd_go;
   logic        mapped;
   logic [7:0]  rd_byte;
   logic        ext_rise;
   logic        ext_fall;
   logic        cap_rise;
   logic        cap_fall;
   logic        sub_tick;

   // ==========================================
   // Control field decode
   assign mode               = mode_t'(timer_control_one[7:6]);
   assign act                = action_t'(timer_control_one[5:4]);
   assign initial_level_ctrl = timer_control_one[`C1_INIT];
   assign output_invert      = timer_control_one[`C1_INV];
   assign duty_period_swap   = timer_control_one[`C1_DPX];
   assign clear_select       = timer_control_one[`C1_CCLR];
   assign counter_enable_bit = ctrl0_ff[`C0_EN];
   assign single = (mode == MODE_PWM) && (act == ACT_TOGGLE);

   // ==========================================
   // Pin synchronisers, two stages before use
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         ext_sync_ff <= 3'b000;
         cap_sync_ff <= 3'b000;
      end else begin
         ext_sync_ff <= {ext_sync_ff[1:0], ext_clk};
         cap_sync_ff <= {cap_sync_ff[1:0], cap_in};
      end
   end
   // Edges seen between stage two and three only
   assign ext_rise = ext_sync_ff[1] & ~ext_sync_ff[2];
   assign ext_fall = ~ext_sync_ff[1] & ext_sync_ff[2];
   assign cap_rise = cap_sync_ff[1] & ~cap_sync_ff[2];
   assign cap_fall = ~cap_sync_ff[1] & cap_sync_ff[2];

   // ==========================================
   // Prescalers, free running
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         pre_ff <= 6'h00;
         sub_ff <= 16'h0000;
      end else begin
         pre_ff <= pre_ff + 6'h01;
         if (sub_tick)
            sub_ff <= 16'h0000;
         else
            sub_ff <= sub_ff + 16'h0001;
      end
   end
   assign sub_tick = (sub_ff == 16'(SUB_DIV - 1));

   // Timer clock source select
   always_comb begin
      case (ctrl0_ff[6:4])
         3'd0:    src_tick = (pre_ff[1:0] == 2'b11);
         3'd1:    src_tick = 1'b1;
         3'd2:    src_tick = (pre_ff[3:0] == 4'hF);
         3'd3:    src_tick = (pre_ff == 6'h3F);
         3'd6:    src_tick = ext_rise;
         3'd7:    src_tick = ext_fall;
         default: src_tick = sub_tick;
      endcase
   end
   assign tick = counter_enable_bit & ~ctrl0_ff[`C0_PAUSE]
               & src_tick;
   assign en_rise = counter_enable_bit & ~en_prev_ff;

   // ==========================================
   // Comparators and clear select
   assign cnt_inc = cnt_ff + 16'h0001;
   assign a_hit = tick && (cnt_inc == cmp_a_ff)
                  && (mode != MODE_CAPTURE);
   // P value zero means wrap at the top of the count
   assign p_hit = tick && ((compare_p_reg == 8'h00)
                  ? (cnt_ff == 16'hFFFF)
                  : (cnt_inc[15:8] == compare_p_reg
                     && cnt_inc[7:0] == 8'h00));
   always_comb begin
      case (mode)
         MODE_CAPTURE: cnt_clr = p_hit;
         MODE_PWM:     cnt_clr = single ? 1'b0 :
                                 (duty_period_swap ? a_hit : p_hit);
         default:      cnt_clr = clear_select ? a_hit : p_hit;
      endcase
   end

   // ==========================================
   // Counter; only an enable rise clears it from software
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         cnt_ff     <= `RST_WORD;
         en_prev_ff <= 1'b0;
      end else begin
         en_prev_ff <= counter_enable_bit;
         if (en_rise)
            cnt_ff <= `RST_WORD;
         else if (tick)
            cnt_ff <= cnt_clr ? `RST_WORD : cnt_inc;
      end
   end

   // ==========================================
   // Capture event on the chosen edge
   always_comb begin
      case (act)
         ACT_HOLD:   cap_evt = cap_rise;
         ACT_LOW:    cap_evt = cap_fall;
         ACT_HIGH:   cap_evt = cap_rise | cap_fall;
         default:    cap_evt = 1'b0;
      endcase
      cap_evt = cap_evt && (mode == MODE_CAPTURE)
                && counter_enable_bit;
   end

   // ==========================================
   // Sticky flags; a set beats a same-cycle clear
   assign set_a = a_hit | cap_evt;
   assign set_p = p_hit && !single &&
                  !(clear_select && (mode == MODE_COMPARE
                    || mode == MODE_COUNT));
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         flag_a_ff <= 1'b0;
         flag_p_ff <= 1'b0;
      end else begin
         if (set_a)
            flag_a_ff <= 1'b1;
         else if (wr_go && paddr == `OFS_FLAGS
                  && pwdata[`FL_A])
            flag_a_ff <= 1'b0;
         if (set_p)
            flag_p_ff <= 1'b1;
         else if (wr_go && paddr == `OFS_FLAGS
                  && pwdata[`FL_P])
            flag_p_ff <= 1'b0;
      end
   end

   // ==========================================
   // PWM duty level; duty at or past period gives 100%
   always_comb begin
      if (!duty_period_swap)
         duty = {1'b0, cmp_a_ff};
      else if (compare_p_reg == 8'h00)
         duty = 17'h1_0000;
      else
         duty = {1'b0, compare_p_reg, 8'h00};
   end
   assign pwm_on = ({1'b0, cnt_ff} < duty);

   // ==========================================
   // Pin level before polarity
   always_comb begin
      nxt_pin = pin_lvl_ff;
      case (mode)
         MODE_COMPARE: begin
            if (en_rise)
               nxt_pin = initial_level_ctrl;
            else if (a_hit) begin
               case (act)
                  ACT_LOW:    nxt_pin = 1'b0;
                  ACT_HIGH:   nxt_pin = 1'b1;
                  ACT_TOGGLE: nxt_pin = ~pin_lvl_ff;
                  default:    nxt_pin = pin_lvl_ff;
               endcase
            end
         end
         MODE_PWM: begin
            // Initial-level bit picks the active level
            case (act)
               ACT_HOLD:   nxt_pin = ~initial_level_ctrl;
               ACT_LOW:    nxt_pin = initial_level_ctrl;
               ACT_HIGH:   nxt_pin = pwm_on ? initial_level_ctrl
                                            : ~initial_level_ctrl;
               default:    nxt_pin = counter_enable_bit
                                     && !a_hit
                                     ? initial_level_ctrl
                                     : ~initial_level_ctrl;
            endcase
            if (en_rise && act != ACT_TOGGLE)
               nxt_pin = initial_level_ctrl;
         end
         default: nxt_pin = pin_lvl_ff;
      endcase
   end

   // Pin register; counter mode leaves the pin unused
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         pin_lvl_ff <= 1'b0;
         out_pin_ff <= 1'b0;
      end else begin
         pin_lvl_ff <= nxt_pin;
         if (mode == MODE_COUNT)
            out_pin_ff <= 1'b0;
         else
            out_pin_ff <= nxt_pin ^ output_invert;
      end
   end
   assign timer_output_pin = out_pin_ff;

   // ==========================================
   // APB decode: one wait state, then pready
   assign wr_go = psel & penable & pready_ff & pwrite;
   assign rd_go = psel & penable & ~pready_ff;
   always_comb begin
      mapped  = 1'b1;
      rd_byte = 8'h00;
      if (paddr == `OFS_CTRL0)
         rd_byte = {ctrl0_ff[7:3], 3'b000};
      else if (paddr == `OFS_CTRL1)
         rd_byte = timer_control_one;
      else if (paddr == `OFS_CNT_LO)
         rd_byte = cnt_ff[7:0];
      else if (paddr == `OFS_CNT_HI)
         rd_byte = cnt_ff[15:8];
      else if (paddr == `OFS_CMPA_LO)
         rd_byte = cmp_a_ff[7:0];
      else if (paddr == `OFS_CMPA_HI)
         rd_byte = cmp_a_ff[15:8];
      else if (paddr == `OFS_CMPP)
         rd_byte = compare_p_reg;
      else if (paddr == `OFS_FLAGS)
         rd_byte = {6'h00, flag_p_ff, flag_a_ff};
      else
         mapped = 1'b0;
   end

   // Bus answer registers
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         pready_ff  <= 1'b0;
         pslverr_ff <= 1'b0;
         prdata_ff  <= 32'h0000_0000;
      end else begin
         pready_ff  <= rd_go;
         pslverr_ff <= rd_go & ~mapped;
         if (rd_go && !pwrite)
            prdata_ff <= {24'h00_0000, rd_byte};
      end
   end
   assign prdata  = prdata_ff;
   assign pready  = pready_ff;
   assign pslverr = pslverr_ff;

   // ==========================================
   // Control registers; hardware enable changes win
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         ctrl0_ff          <= `RST_BYTE;
         timer_control_one <= `RST_BYTE;
      end else begin
         if (wr_go && paddr == `OFS_CTRL0)
            ctrl0_ff <= {pwdata[7:3], 3'b000};
         if (wr_go && paddr == `OFS_CTRL1)
            timer_control_one <= pwdata[7:0];
         // Pulse ends on an A match; the pin edge starts one
         if (single && a_hit)
            ctrl0_ff[`C0_EN] <= 1'b0;
         else if (single && ext_rise)
            ctrl0_ff[`C0_EN] <= 1'b1;
      end
   end

   // Compare registers; a capture overrides a compare A write
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         cmp_a_ff      <= `RST_WORD;
         compare_p_reg <= `RST_BYTE;
      end else begin
         if (cap_evt)
            cmp_a_ff <= cnt_ff;
         else if (wr_go && paddr == `OFS_CMPA_LO)
            cmp_a_ff[7:0] <= pwdata[7:0];
         else if (wr_go && paddr == `OFS_CMPA_HI)
            cmp_a_ff[15:8] <= pwdata[7:0];
         if (wr_go && paddr == `OFS_CMPP)
            compare_p_reg <= pwdata[7:0];
      end
   end

   // ==========================================
   // Checks
   default clocking cb @(posedge clock); endclocking
   default disable iff (rst);

   sequence cmp_hit_s;
      mode == MODE_COMPARE && a_hit && !en_rise;
   endsequence

   act_high_a: assert property (
      cmp_hit_s and act == ACT_HIGH |=> pin_lvl_ff)
      else $error("high action did not drive pin");
   act_hold_a: assert property (
      cmp_hit_s and act == ACT_HOLD |=> $stable(pin_lvl_ff))
      else $error("hold action moved pin");
   act_toggle_a: assert property (
      cmp_hit_s and act == ACT_TOGGLE
      |=> pin_lvl_ff != $past(pin_lvl_ff))
      else $error("toggle action did not toggle");
   init_level_a: assert property (
      en_rise && mode == MODE_COMPARE
      |=> pin_lvl_ff == $past(initial_level_ctrl))
      else $error("enable rise missed initial level");
   pin_polarity_a: assert property (
      $past(mode) != MODE_COUNT
      |-> timer_output_pin == (pin_lvl_ff ^ $past(output_invert)))
      else $error("pin polarity wrong");
   a_clear_a: assert property (
      mode == MODE_COMPARE && clear_select && a_hit && !en_rise
      |=> cnt_ff == 16'h0000 && flag_a_ff)
      else $error("A match did not clear counter");
   wrap_flag_a: assert property (
      mode == MODE_COMPARE && !clear_select && tick
      && compare_p_reg == 8'h00 && cnt_ff == 16'hFFFF
      |=> flag_p_ff && cnt_ff == 16'h0000)
      else $error("overflow did not set P flag");
   no_p_flag_a: assert property (
      mode == MODE_COMPARE && clear_select && !flag_p_ff
      |=> !flag_p_ff || !$past(clear_select)
          || $past(mode) != MODE_COMPARE)
      else $error("P flag set with A clear");
   p_quiet_a: assert property (
      mode == MODE_COMPARE && p_hit && !a_hit && !en_rise
      |=> $stable(pin_lvl_ff))
      else $error("P match moved pin");
   freeze_a: assert property (
      $fell(counter_enable_bit) |=> $stable(cnt_ff) [*2])
      else $error("counter moved while off");
   flag_sticky_a: assert property (
      flag_a_ff && !(wr_go && paddr == `OFS_FLAGS)
      |=> flag_a_ff)
      else $error("A flag dropped without clear");
endmodule

// [pin_watch_model.sv]
module pin_watch_model (
   input  wire logic        clock,            // Bench clock
   input  wire logic        rst,              // Async reset
   input  wire logic        timer_output_pin, // Pin under watch
   input  wire logic        tally_clr,        // Restart the tally
   output logic             ext_clk,          // Count pin, idle low
   output logic             cap_in,           // Capture pin, idle low
   output logic [15:0]      high_tally        // Cycles seen high
);
   timeunit 1ns;
   timeprecision 1ns;
   // ==========================================
   // Load side: input pins rest low, no pulses sent
   assign ext_clk = 1'b0;
   assign cap_in  = 1'b0;
   // Count high cycles, so duty is judged at the pin itself
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         high_tally <= 16'h0000;
      end else if (tally_clr) begin
         high_tally <= 16'h0000;
      end else if (timer_output_pin === 1'b1) begin
         high_tally <= high_tally + 16'h0001;
      end
   end
endmodule

// [tb_standard_timer.sv]
`include "stm_params.svh"
`define CHECK_EQ(got, exp) \
   begin \
      checked++; \
      if ((got) !== (exp)) begin \
         mismatches++; \
         $display("[FAIL] t=%0t got=%0h exp=%0h", $time, (got), (exp)); \
      end \
   end
module tb_standard_timer;
   timeunit 1ns;
   timeprecision 1ns;
   import stm_pkg::*;
   logic        clock = 1'b0;
   logic        rst = 1'b1;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   addr_t       paddr = 8'h00;
   logic [31:0] pwdata = 32'h0000_0000;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic        ext_clk;
   logic        cap_in;
   logic        timer_output_pin;
   logic        tally_clr = 1'b0;
   logic [15:0] high_tally;
   int          cyc = 0;
   int          t0 = 0;
   int          mismatches = 0;
   int          checked = 0;
   byte_t       rv;
   byte_t       rv2;
   logic        er;
   logic        exp_pin;
   int          el;
   int          ex;
   logic [15:0] ta [3] = '{16'h0180, 16'h0080, 16'h0180};
   logic [2:0]  te [3] = '{3'b010, 3'b110, 3'b101}; // A flag, P flag, cclr
   // ==========================================
   // Clock at 50 ns and a free cycle count for period checks
   always #25 clock = ~clock;
   always @(posedge clock) cyc <= cyc + 1;
   standard_timer #(.SUB_DIV(4)) standard_timer_inst (
      .clock(clock), .rst(rst), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .ext_clk(ext_clk),
      .cap_in(cap_in), .timer_output_pin(timer_output_pin));
   pin_watch_model pin_watch_model_inst (
      .clock(clock), .rst(rst), .timer_output_pin(timer_output_pin),
      .tally_clr(tally_clr), .ext_clk(ext_clk), .cap_in(cap_in),
      .high_tally(high_tally));
   // ==========================================
   // Verdict and end of run
   task automatic complete_run();
      $display("Counts: checked=%0d mismatches=%0d", checked, mismatches);
      if (mismatches == 0 && checked > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   // One APB transfer; request held until pready is sampled high
   task automatic apb_xfer(input addr_t a, input logic w, input byte_t d,
                           output byte_t rd, output logic err);
      int n;
      @(posedge clock);
      psel <= 1'b1;
      penable <= 1'b0;
      paddr <= a;
      pwrite <= w;
      pwdata <= {24'h00_0000, d};
      @(posedge clock);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge clock);
         n++;
      end while (pready !== 1'b1 && n < 64);
      rd = prdata[7:0];
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (n >= 64) begin
         mismatches++;
         complete_run();
      end
   endtask
   task automatic wr(input addr_t a, input byte_t d);
      byte_t r;
      logic e;
      apb_xfer(a, 1'b1, d, r, e);
   endtask
   task automatic rd8(input addr_t a, output byte_t d);
      logic e;
      apb_xfer(a, 1'b0, 8'h00, d, e);
   endtask
   // Poll a flag bit under a bound; a stuck flag ends the run
   task automatic wait_flag(input int b, output int elapsed);
      byte_t f;
      int n;
      f = 8'h00;
      n = 0;
      while (f[b] !== 1'b1 && n < 20000) begin
         rd8(`OFS_FLAGS, f);
         n++;
      end
      elapsed = cyc - t0;
      if (n >= 20000) begin
         mismatches++;
         complete_run();
      end
   endtask
   // Program with the timer off, then raise enable with the fast clock
   task automatic setup(input byte_t c1, input logic [15:0] a,
                        input byte_t p);
      wr(`OFS_CTRL0, 8'h10);
      wr(`OFS_FLAGS, 8'h03);
      wr(`OFS_CTRL1, c1);
      wr(`OFS_CMPA_LO, a[7:0]);
      wr(`OFS_CMPA_HI, a[15:8]);
      wr(`OFS_CMPP, p);
      wr(`OFS_CTRL0, 8'h18);
      t0 = cyc;
   endtask
   // ==========================================
   // Main sequence
   initial begin
      repeat (8) @(posedge clock);
      rst <= 1'b0;
      // Reset values, read-only counter, unmapped place
      for (int i = 1; i < 7; i++) begin
         rd8(addr_t'(i * 4), rv);
         `CHECK_EQ(rv, 8'h00);
      end
      wr(`OFS_CNT_LO, 8'h5a);
      rd8(`OFS_CNT_LO, rv);
      `CHECK_EQ(rv, 8'h00);
      wr(`OFS_CMPA_HI, 8'ha5);
      rd8(`OFS_CMPA_HI, rv);
      `CHECK_EQ(rv, 8'ha5);
      apb_xfer(8'h20, 1'b0, 8'h00, rv, er);
      `CHECK_EQ({er, rv}, 9'h100);
      $display("Test registers done");
      // Every action, initial level and inversion on compare A
      for (int inv = 0; inv < 2; inv++) begin
         for (int act = 0; act < 4; act++) begin
            for (int ini = 0; ini < 2; ini++) begin
               setup({2'b00, 2'(act), 1'(ini), 1'(inv), 2'b01},
                     16'h0028, 8'h00);
               repeat (2) @(posedge clock);
               `CHECK_EQ(timer_output_pin, 1'(ini ^ inv));
               wait_flag(0, el);
               `CHECK_EQ(1'(el >= 40 && el <= 48), 1'b1);
               case (act)
                  0: exp_pin = 1'(ini);
                  1: exp_pin = 1'b0;
                  2: exp_pin = 1'b1;
                  default: exp_pin = 1'(~ini);
               endcase
               `CHECK_EQ(timer_output_pin, exp_pin ^ 1'(inv));
               rd8(`OFS_FLAGS, rv);
               `CHECK_EQ(rv[1], 1'b0);
            end
         end
      end
      $display("Test compare actions done");
      // Clear select against P and A, pin driven by A only
      for (int k = 0; k < 3; k++) begin
         setup({4'b0010, 3'b000, te[k][0]}, ta[k], 8'h01);
         rd8(`OFS_CNT_HI, rv);
         `CHECK_EQ(rv, 8'h00);
         repeat (1200) @(posedge clock);
         rd8(`OFS_FLAGS, rv);
         `CHECK_EQ(rv[1:0], {te[k][1], te[k][2]});
         `CHECK_EQ(timer_output_pin, te[k][2]);
         rd8(`OFS_CNT_HI, rv);
         `CHECK_EQ(rv <= byte_t'(te[k][0]), 1'b1);
      end
      // Flags hold and the count freezes once enable falls
      wr(`OFS_CTRL0, 8'h10);
      rd8(`OFS_CNT_LO, rv);
      repeat (20) @(posedge clock);
      rd8(`OFS_CNT_LO, rv2);
      `CHECK_EQ(rv2, rv);
      rd8(`OFS_FLAGS, rv);
      `CHECK_EQ(rv[0], 1'b1);
      wr(`OFS_FLAGS, 8'h01);
      rd8(`OFS_FLAGS, rv);
      `CHECK_EQ(rv[0], 1'b0);
      $display("Test clear select done");
      // P period: N times 256, or a full wrap when P is zero
      for (int n = 1; n < 5; n += 3) begin
         setup(8'h00, 16'hffff, byte_t'(n % 4));
         wait_flag(1, el);
         ex = (n == 4) ? 65536 : n * 256;
         `CHECK_EQ(1'(el >= ex && el <= ex + 8), 1'b1);
      end
      $display("Test P period done");
      // Counter mode: pin unused, invert and initial level ignored
      setup(8'b1110_1101, 16'h0028, 8'h00);
      wait_flag(0, el);
      `CHECK_EQ(timer_output_pin, 1'b0);
      // Capture mode: clear select ignored, P match still clears
      setup(8'b0111_0001, 16'h0028, 8'h01);
      wait_flag(1, el);
      `CHECK_EQ(1'(el >= 256 && el <= 264), 1'b1);
      rd8(`OFS_FLAGS, rv);
      `CHECK_EQ(rv[0], 1'b0);
      // PWM forced levels follow the active level
      for (int i = 0; i < 4; i++) begin
         setup({3'b100, 1'(i), 1'(i >> 1), 3'b000}, 16'h0028, 8'h01);
         repeat (3) @(posedge clock);
         `CHECK_EQ(timer_output_pin, 1'((i ^ (i >> 1) ^ 1) & 1));
      end
      // PWM duty with and without the swap; clear select ignored
      for (int d = 0; d < 2; d++) begin
         setup({6'b1010_10, 1'(d), 1'b1}, 16'h0040, 8'h01);
         repeat (600) @(posedge clock);
         tally_clr <= 1'b1;
         @(posedge clock);
         tally_clr <= 1'b0;
         // 512 samples after the clear edge: two periods, or eight with the swap
         repeat (513) @(posedge clock);
         `CHECK_EQ(high_tally, (d == 0) ? 16'h0080 : 16'h0200);
      end
      $display("Test modes done");
      complete_run();
   end
endmodule
